// file: hw/perf_second_pkg.sv
// Constants and types shared by the performance second counter.
// Assumes a 100 MHz core clock and a once-a-second strobe from elsewhere.
package perf_second_pkg;
  localparam int COUNT_W = 32;
  // Seconds in the entry and exit decision windows
  localparam int WINDOW_SECONDS = 10;
  localparam logic [3:0] WINDOW_LAST = 4'h9;
  localparam logic [3:0] WINDOW_FULL = 4'hA;
  localparam logic [COUNT_W-1:0] WINDOW_COUNT = 32'h0000000A;
  // Severe error threshold: errors times this reaching the bit count is 1e-3
  localparam logic [47:0] SEVERE_RATIO_DEN = 48'h0000000003E8;
  // Objectives expressed per thousand available seconds
  localparam logic [47:0] OBJ_DEN = 48'h0000000003E8;
  localparam logic [15:0] ERR_OBJ_G821 = 16'h0050;
  localparam logic [15:0] ERR_OBJ_G826 = 16'h0028;
  localparam logic [15:0] ERR_OBJ_M2100 = 16'h0014;
  localparam logic [15:0] SEV_OBJ_G821 = 16'h0002;
  localparam logic [15:0] SEV_OBJ_G826 = 16'h0002;
  localparam logic [15:0] SEV_OBJ_M2100 = 16'h0001;
  // Reset values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h00000000;
  localparam logic [3:0] RUN_RESET = 4'h0;

  typedef enum logic [1:0] {
    std_g821 = 2'b00,
    std_g826 = 2'b01,
    std_m2100 = 2'b10
  } objective_std_e;

  typedef enum logic {
    st_available = 1'b0,
    st_unavailable = 1'b1
  } avail_state_e;
endpackage : perf_second_pkg

// file: hw/perf_second_counter.sv
// Per-second performance statistics for a received PDH signal.
// Assumes the framer delivers error counts, bit counts and alarms on core_clk,
// valid in the cycle where sec_tick pulses; power_ok comes from a pin.
// Functional notes
// - Count seconds with one or more errors as errored while available.
// - Count severe seconds at 1e-3 ratio or alarm; count alarm seconds.
// - Background errors accumulate from non-severe seconds; shown only for G.826.
// - Ten consecutive severe seconds enter unavailable time from the run's start.
// - Ten consecutive non-severe seconds leave unavailable time, ending before them.
// - Pending entry counts as available, pending exit as unavailable; then recount.
// - Total time accumulates only while power is present.
// - Available time equals total time minus unavailable time.
// - Count seconds with no errors as error-free while available.
// - Pass when ratio is at or below objective of the selected standard.
module perf_second_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Timing and control
  input wire logic sec_tick,
  input wire logic meas_clear,
  input wire logic power_ok_pin,
  input wire logic [1:0] objective_std,
  // Upstream per-second indications
  input wire logic [perf_second_pkg::COUNT_W-1:0] err_count,
  input wire logic [perf_second_pkg::COUNT_W-1:0] bit_count,
  input wire logic alarm_indication_signal,
  input wire logic loss_of_signal,
  // Results
  output logic [perf_second_pkg::COUNT_W-1:0] errored_second_count,
  output logic [perf_second_pkg::COUNT_W-1:0] severe_error_second_count,
  output logic [perf_second_pkg::COUNT_W-1:0] alarm_second_count,
  output logic [perf_second_pkg::COUNT_W-1:0] error_free_second_count,
  output logic [perf_second_pkg::COUNT_W-1:0] background_block_error_count,
  output logic background_block_error_shown,
  output logic [perf_second_pkg::COUNT_W-1:0] total_time,
  output logic [perf_second_pkg::COUNT_W-1:0] unavailable_time,
  output logic [perf_second_pkg::COUNT_W-1:0] available_time,
  output logic unavailable,
  output logic errored_pass,
  output logic severe_pass
);
  import perf_second_pkg::*;

  logic power_meta;
  logic power_ok;
  avail_state_e state;
  logic [3:0] bad_run;
  logic [3:0] good_run;
  logic [COUNT_W-1:0] bg_raw;
  // Only the nine previous seconds are kept; the current one completes the window
  logic hist_err [WINDOW_SECONDS-1];
  logic hist_sev [WINDOW_SECONDS-1];
  logic hist_alm [WINDOW_SECONDS-1];
  logic hist_clean [WINDOW_SECONDS-1];
  logic [COUNT_W-1:0] hist_bg [WINDOW_SECONDS-1];
  logic cur_err, cur_sev, cur_alm, cur_clean, alarm, step, normal, enter_now, exit_now;
  logic [COUNT_W-1:0] cur_bg;
  logic [COUNT_W-1:0] w_err, w_sev, w_alm, w_clean, w_bg;
  logic [COUNT_W-1:0] add_err, add_sev, add_alm, add_clean, add_bg;
  logic [COUNT_W-1:0] sub_err, sub_sev, sub_alm, sub_clean, sub_bg;
  logic [15:0] err_obj, sev_obj;

  // Power indication arrives from a pin, so it is synchronised first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_meta <= 1'b0;
      power_ok <= 1'b0;
    end else begin
      power_meta <= power_ok_pin;
      power_ok <= power_meta;
    end
  end

  // Classify the second that ends at this strobe
  always_comb begin
    alarm = alarm_indication_signal | loss_of_signal;
    cur_err = (err_count != COUNT_RESET);
    cur_clean = (err_count == COUNT_RESET);
    cur_sev = alarm |
      ((48'(err_count) * SEVERE_RATIO_DEN) >= 48'(bit_count) && cur_err);
    cur_alm = alarm;
    cur_bg = cur_sev ? COUNT_RESET : err_count;
    // Seconds lost to a power failure are neither timed nor classified
    step = sec_tick & power_ok & ~meas_clear;
    normal = step && state == st_available;
    enter_now = normal && cur_sev && bad_run == WINDOW_LAST;
    exit_now = step && state == st_unavailable && !cur_sev && good_run == WINDOW_LAST;
  end

  // Window sums over this second plus the nine before it
  always_comb begin
    w_err = 32'(cur_err);
    w_sev = 32'(cur_sev);
    w_alm = 32'(cur_alm);
    w_clean = 32'(cur_clean);
    w_bg = cur_bg;
    for (int i = 0; i < WINDOW_SECONDS - 1; i++) begin
      w_err = w_err + 32'(hist_err[i]);
      w_sev = w_sev + 32'(hist_sev[i]);
      w_alm = w_alm + 32'(hist_alm[i]);
      w_clean = w_clean + 32'(hist_clean[i]);
      w_bg = w_bg + hist_bg[i];
    end
  end

  // Deltas: pending entry counts normally, then the run is taken back out;
  // pending exit counts nothing, then the run is credited back in
  always_comb begin
    add_err = exit_now ? w_err : (normal ? 32'(cur_err) : COUNT_RESET);
    add_sev = exit_now ? w_sev : (normal ? 32'(cur_sev) : COUNT_RESET);
    add_alm = exit_now ? w_alm : (normal ? 32'(cur_alm) : COUNT_RESET);
    add_clean = exit_now ? w_clean : (normal ? 32'(cur_clean) : COUNT_RESET);
    add_bg = exit_now ? w_bg : (normal ? cur_bg : COUNT_RESET);
    sub_err = enter_now ? w_err : COUNT_RESET;
    sub_sev = enter_now ? w_sev : COUNT_RESET;
    sub_alm = enter_now ? w_alm : COUNT_RESET;
    sub_clean = enter_now ? w_clean : COUNT_RESET;
    sub_bg = enter_now ? w_bg : COUNT_RESET;
  end

  // Result counters
  always_ff @(posedge core_clk) begin
    if (srst || meas_clear) begin
      errored_second_count <= COUNT_RESET;
      severe_error_second_count <= COUNT_RESET;
      alarm_second_count <= COUNT_RESET;
      error_free_second_count <= COUNT_RESET;
      bg_raw <= COUNT_RESET;
    end else begin
      errored_second_count <= errored_second_count + add_err - sub_err;
      severe_error_second_count <= severe_error_second_count + add_sev - sub_sev;
      alarm_second_count <= alarm_second_count + add_alm - sub_alm;
      error_free_second_count <= error_free_second_count + add_clean - sub_clean;
      bg_raw <= bg_raw + add_bg - sub_bg;
    end
  end

  // Time counters; unavailable time gains the whole run on entry, loses it on exit
  always_ff @(posedge core_clk) begin
    if (srst || meas_clear) begin
      total_time <= COUNT_RESET;
      unavailable_time <= COUNT_RESET;
    end else if (step) begin
      total_time <= total_time + 32'h00000001;
      if (enter_now) begin
        unavailable_time <= unavailable_time + WINDOW_COUNT;
      end else if (exit_now) begin
        unavailable_time <= unavailable_time + 32'h00000001 - WINDOW_COUNT;
      end else if (state == st_unavailable) begin
        unavailable_time <= unavailable_time + 32'h00000001;
      end
    end
  end

  // Availability state and run lengths
  always_ff @(posedge core_clk) begin
    if (srst || meas_clear) begin
      state <= st_available;
      bad_run <= RUN_RESET;
      good_run <= RUN_RESET;
    end else if (step) begin
      unique case (state)
        st_available: begin
          good_run <= RUN_RESET;
          bad_run <= cur_sev ? bad_run + 4'h1 : RUN_RESET;
          if (enter_now) begin
            state <= st_unavailable;
            bad_run <= RUN_RESET;
          end
        end
        st_unavailable: begin
          bad_run <= RUN_RESET;
          good_run <= cur_sev ? RUN_RESET : good_run + 4'h1;
          if (exit_now) begin
            state <= st_available;
            good_run <= RUN_RESET;
          end
        end
      endcase
    end
  end

  // History of the last seconds, newest at index zero
  always_ff @(posedge core_clk) begin
    if (srst || meas_clear) begin
      for (int i = 0; i < WINDOW_SECONDS - 1; i++) begin
        hist_err[i] <= 1'b0;
        hist_sev[i] <= 1'b0;
        hist_alm[i] <= 1'b0;
        hist_clean[i] <= 1'b0;
        hist_bg[i] <= COUNT_RESET;
      end
    end else if (step) begin
      hist_err[0] <= cur_err;
      hist_sev[0] <= cur_sev;
      hist_alm[0] <= cur_alm;
      hist_clean[0] <= cur_clean;
      hist_bg[0] <= cur_bg;
      for (int i = 1; i < WINDOW_SECONDS - 1; i++) begin
        hist_err[i] <= hist_err[i-1];
        hist_sev[i] <= hist_sev[i-1];
        hist_alm[i] <= hist_alm[i-1];
        hist_clean[i] <= hist_clean[i-1];
        hist_bg[i] <= hist_bg[i-1];
      end
    end
  end

  assign unavailable = (state == st_unavailable);
  assign available_time = total_time - unavailable_time;
  assign background_block_error_shown = (objective_std == std_g826);
  // Hidden rather than frozen, so switching standard shows the live count
  assign background_block_error_count = background_block_error_shown ? bg_raw : COUNT_RESET;

  // Objectives of the selected standard; the unused code falls back to G.821
  assign err_obj = (objective_std == std_g826) ? ERR_OBJ_G826 :
    (objective_std == std_m2100) ? ERR_OBJ_M2100 : ERR_OBJ_G821;
  assign sev_obj = (objective_std == std_g826) ? SEV_OBJ_G826 :
    (objective_std == std_m2100) ? SEV_OBJ_M2100 : SEV_OBJ_G821;

  // Cross-multiplied ratio test avoids a divider; an empty period passes
  always_ff @(posedge core_clk) begin
    if (srst || meas_clear) begin
      errored_pass <= 1'b1;
      severe_pass <= 1'b1;
    end else if (sec_tick) begin
      errored_pass <= (48'(errored_second_count) * OBJ_DEN)
        <= (48'(err_obj) * 48'(available_time));
      severe_pass <= (48'(severe_error_second_count) * OBJ_DEN)
        <= (48'(sev_obj) * 48'(available_time));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst || meas_clear);

  property p_total_step;
    step |=> total_time == $past(total_time) + 32'h00000001;
  endproperty
  a_total_step: assert property (p_total_step) else $error("total time missed a second");

  property p_total_nopower;
    sec_tick && !power_ok |=> $stable(total_time);
  endproperty
  a_total_nopower: assert property (p_total_nopower) else $error("timed during power loss");

  property p_avail_bound;
    available_time <= total_time;
  endproperty
  a_avail_bound: assert property (p_avail_bound) else $error("available exceeds total");

  // The entry second itself is taken back out, so it is excluded from the plain count checks
  property p_err_sec;
    step && !unavailable && cur_err && !enter_now |=>
      errored_second_count == $past(errored_second_count) + 32'h00000001;
  endproperty
  a_err_sec: assert property (p_err_sec) else $error("errored second not counted");
  property p_clean_sec;
    step && !unavailable && cur_clean && !enter_now |=>
      error_free_second_count == $past(error_free_second_count) + 32'h00000001;
  endproperty
  a_clean_sec: assert property (p_clean_sec) else $error("error free second missed");
  property p_alarm_sec;
    step && !unavailable && alarm && !enter_now |=>
      alarm_second_count == $past(alarm_second_count) + 32'h00000001 &&
      severe_error_second_count == $past(severe_error_second_count) + 32'h00000001;
  endproperty
  a_alarm_sec: assert property (p_alarm_sec) else $error("alarm second not counted");
  property p_enter;
    step && !unavailable && cur_sev && bad_run == WINDOW_LAST |=>
      unavailable && unavailable_time == $past(unavailable_time) + WINDOW_COUNT;
  endproperty
  a_enter: assert property (p_enter) else $error("unavailable entry wrong");
  property p_exit;
    step && unavailable && !cur_sev && good_run == WINDOW_LAST |=>
      !unavailable && unavailable_time == $past(unavailable_time) - 32'h00000009;
  endproperty
  a_exit: assert property (p_exit) else $error("unavailable exit wrong");
  property p_pending_exit;
    step && unavailable && !exit_now |=>
      unavailable_time == $past(unavailable_time) + 32'h00000001 && $stable(errored_second_count);
  endproperty
  a_pending_exit: assert property (p_pending_exit) else $error("pending exit miscounted");
  property p_bg_hidden;
    objective_std != std_g826 |-> background_block_error_count == COUNT_RESET;
  endproperty
  a_bg_hidden: assert property (p_bg_hidden) else $error("background errors shown");
  property p_pass_empty;
    sec_tick && available_time == COUNT_RESET |=> errored_pass && severe_pass;
  endproperty
  a_pass_empty: assert property (p_pass_empty) else $error("empty period failed");
endmodule : perf_second_counter

// file: testbench/pdh_framer_model.sv
// Upstream framer stand-in: emits one-second indications when the bench asks.
// Assumes requests change at the falling edge; the strobe follows one falling edge later.
module pdh_framer_model (
  // Clock
  input wire logic core_clk,
  // Requests from the bench
  input wire logic fire,
  input wire logic [31:0] req_err,
  input wire logic [31:0] req_bits,
  input wire logic req_alarm,
  input wire logic req_loss,
  // Toward the counter
  output logic sec_tick,
  output logic [31:0] err_count,
  output logic [31:0] bit_count,
  output logic alarm_indication_signal,
  output logic loss_of_signal
);
  timeunit 1ns;
  timeprecision 1ps;

  // Defined levels before the first strobe
  initial begin
    sec_tick = 1'b0;
    err_count = 32'h00000000;
    bit_count = 32'h00000000;
    alarm_indication_signal = 1'b0;
    loss_of_signal = 1'b0;
  end

  // Counts are only valid with the strobe, so they are scrambled in between
  always @(negedge core_clk) begin
    sec_tick <= fire;
    err_count <= fire ? req_err : ~err_count;
    bit_count <= fire ? req_bits : ~bit_count;
    alarm_indication_signal <= req_alarm;
    loss_of_signal <= req_loss;
  end
endmodule : pdh_framer_model

// file: testbench/tb_perf_second_counter.sv
// Self-checking bench for the performance second counter.
// Assumes the framer model above; all inputs change at the falling edge.
module tb_perf_second_counter;
  import perf_second_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BITS = 32'h001F4000;
  logic core_clk = 1'b0;
  logic srst, meas_clear, power_ok_pin, fire, req_alarm, req_loss;
  logic [1:0] objective_std;
  logic [31:0] req_err, req_bits, err_count, bit_count;
  logic sec_tick, ind_alarm, ind_loss, bg_shown, unavailable, errored_pass, severe_pass;
  logic [COUNT_W-1:0] err_secs, sev_secs, alm_secs, clean_secs, bg_errs, total, unav, avail;
  int n_errors = 0;
  int checks_done = 0;

  always #5 core_clk = ~core_clk;

  pdh_framer_model pdh_framer_model_inst (.core_clk(core_clk), .fire(fire), .req_err(req_err),
    .req_bits(req_bits), .req_alarm(req_alarm), .req_loss(req_loss), .sec_tick(sec_tick),
    .err_count(err_count), .bit_count(bit_count), .alarm_indication_signal(ind_alarm),
    .loss_of_signal(ind_loss));

  perf_second_counter perf_second_counter_inst (.core_clk(core_clk), .srst(srst),
    .sec_tick(sec_tick), .meas_clear(meas_clear), .power_ok_pin(power_ok_pin),
    .objective_std(objective_std), .err_count(err_count), .bit_count(bit_count),
    .alarm_indication_signal(ind_alarm), .loss_of_signal(ind_loss),
    .errored_second_count(err_secs), .severe_error_second_count(sev_secs),
    .alarm_second_count(alm_secs), .error_free_second_count(clean_secs),
    .background_block_error_count(bg_errs), .background_block_error_shown(bg_shown),
    .total_time(total), .unavailable_time(unav), .available_time(avail),
    .unavailable(unavailable), .errored_pass(errored_pass), .severe_pass(severe_pass));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // One second of indications; returns once the counters have settled
  task automatic step(input logic [31:0] e, input logic a, input logic l);
    @(negedge core_clk);
    fire <= 1'b1;
    req_err <= e;
    req_bits <= BITS;
    req_alarm <= a;
    req_loss <= l;
    @(negedge core_clk);
    fire <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : step

  task automatic clr();
    @(negedge core_clk);
    meas_clear <= 1'b1;
    @(negedge core_clk);
    meas_clear <= 1'b0;
    @(negedge core_clk);
  endtask : clr

  task automatic t_classes();
    objective_std <= 2'b01;
    clr();
    step(32'h00000005, 1'b0, 1'b0);
    check("errored", 32'h1, err_secs);
    check("background", 32'h5, bg_errs);
    check("clean", 32'h0, clean_secs);
    step(32'h00000000, 1'b0, 1'b0);
    check("clean", 32'h1, clean_secs);
    step(32'h00000BB8, 1'b0, 1'b0);
    check("severe", 32'h1, sev_secs);
    check("errored", 32'h2, err_secs);
    check("background", 32'h5, bg_errs);
    step(32'h00000000, 1'b0, 1'b1);
    check("alarm", 32'h1, alm_secs);
    check("severe", 32'h2, sev_secs);
    check("clean", 32'h2, clean_secs);
    check("avail", 32'h4, avail);
    objective_std <= 2'b00;
    @(negedge core_clk);
    check("background", 32'h0, bg_errs);
    check("shown", 32'h0, bg_shown);
    // The spare code must hide the background count as well
    objective_std <= 2'b11;
    @(negedge core_clk);
    check("shown", 32'h0, bg_shown);
    $display("test classes done");
  endtask : t_classes

  task automatic t_unavail();
    clr();
    repeat (9) step(32'h00000000, 1'b1, 1'b0);
    check("unav", 32'h0, unav);
    check("state", 32'h0, unavailable);
    step(32'h00000000, 1'b1, 1'b0);
    check("state", 32'h1, unavailable);
    check("unav", 32'hA, unav);
    check("severe", 32'h0, sev_secs);
    check("alarm", 32'h0, alm_secs);
    check("avail", 32'h0, avail);
    repeat (9) step(32'h00000000, 1'b0, 1'b0);
    check("unav", 32'h13, unav);
    check("state", 32'h1, unavailable);
    step(32'h00000000, 1'b0, 1'b0);
    check("state", 32'h0, unavailable);
    check("unav", 32'hA, unav);
    check("clean", 32'hA, clean_secs);
    check("avail", 32'hA, avail);
    $display("test unavailable done");
  endtask : t_unavail

  // Ticks without power add nothing; the sync lag is covered by the waits
  task automatic t_power();
    power_ok_pin <= 1'b0;
    repeat (4) @(negedge core_clk);
    step(32'h00000000, 1'b0, 1'b0);
    check("total", 32'h14, total);
    power_ok_pin <= 1'b1;
    repeat (4) @(negedge core_clk);
    step(32'h00000000, 1'b0, 1'b0);
    check("total", 32'h15, total);
    $display("test power done");
  endtask : t_power

  // One severe second then clean ones, until the severe ratio just meets its objective;
  // pass reflects counts before each tick
  task automatic t_pass(input logic [1:0] s, input int oe, input int os);
    int prior;
    objective_std <= s;
    clr();
    for (int i = 0; i <= 1000 / os; i++) begin
      prior = (i > 0) ? 1000 : 0;
      step((i == 0) ? 32'h00000BB8 : 32'h00000000, 1'b0, 1'b0);
      check("errored_pass", 32'(prior <= oe * i), errored_pass);
      check("severe_pass", 32'(prior <= os * i), severe_pass);
    end
    $display("test pass std %0d done", s);
  endtask : t_pass

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Watchdog: some 2530 seconds of four cycles each need about 10200 cycles
  initial begin
    #300000;
    n_errors++;
    summarize();
  end

  initial begin
    srst = 1'b1;
    meas_clear = 1'b0;
    power_ok_pin = 1'b1;
    objective_std = 2'b01;
    fire = 1'b0;
    req_err = 32'h00000000;
    req_bits = 32'h00000000;
    req_alarm = 1'b0;
    req_loss = 1'b0;
    repeat (8) @(negedge core_clk);
    srst <= 1'b0;
    repeat (3) @(negedge core_clk);
    t_classes();
    t_unavail();
    t_power();
    t_pass(std_g821, int'(ERR_OBJ_G821), int'(SEV_OBJ_G821));
    t_pass(std_g826, int'(ERR_OBJ_G826), int'(SEV_OBJ_G826));
    t_pass(std_m2100, int'(ERR_OBJ_M2100), int'(SEV_OBJ_M2100));
    t_pass(2'b11, int'(ERR_OBJ_G821), int'(SEV_OBJ_G821));
    summarize();
  end
endmodule : tb_perf_second_counter
